// ===== verilog/scmc_defs.svh
// constants for the serial command mode controller
// Summary of operation
// - thirteen-bit pull-up mask drives line pull-ups
// - mask bits 0..12 map to fixed lines
// - strength output held setting times 100 ms
// - hold setting 0xFF keeps output always on
// - button command repeats pushbutton action count times
// - firmware version query returns fixed sixteen bits
// - hardware version query returns fixed sixteen bits
// - millivolts equal raw times 1200 over 1023
// - inactivity timeout times 100 ms exits command mode
// - exit command leaves command mode at once
// - entry needs guard silence before and after
// - entry character configurable, default plus sign
`ifndef SCMC_DEFS_SVH
`define SCMC_DEFS_SVH
`define SCMC_CLK_MHZ        125
`define SCMC_MS_NS          1000000
`define SCMC_CLK_NS         8
`define SCMC_MS_CYC         (`SCMC_MS_NS / `SCMC_CLK_NS)
`define SCMC_PULLUP_RST     13'h1FFF
`define SCMC_HOLD_RST       8'h28
`define SCMC_HOLD_ALWAYS    8'hFF
`define SCMC_TMO_RST        12'h064
`define SCMC_TMO_MIN        12'h002
`define SCMC_TMO_MAX        12'h28F
`define SCMC_GUARD_RST      12'h3E8
`define SCMC_GUARD_MIN      12'h001
`define SCMC_GUARD_MAX      12'hCE4
`define SCMC_SEQ_CHAR_RST   8'h2B
`define SCMC_SEQ_COUNT      2'h3
`define SCMC_TENTH_MS       7'h64
`define SCMC_VOLT_MUL       32'd1200
`define SCMC_VOLT_DIV       32'd1023
`endif

// ===== verilog/scmc_pkg.sv
// types for the serial command mode controller
package scmc_pkg;
  typedef enum logic [1:0] {
    SCMC_IDLE   = 2'b00,
    SCMC_PRE    = 2'b01,
    SCMC_POST   = 2'b10,
    SCMC_CMD    = 2'b11
  } scmc_mode_t;
  typedef enum logic [2:0] {
    SCMC_OP_NONE    = 3'b000,
    SCMC_OP_EXIT    = 3'b001,
    SCMC_OP_BUTTON  = 3'b010,
    SCMC_OP_FW_VER  = 3'b011,
    SCMC_OP_HW_VER  = 3'b100,
    SCMC_OP_VOLT    = 3'b101,
    SCMC_OP_OTHER   = 3'b110
  } scmc_op_t;
endpackage

// ===== verilog/scmc_ms_tick.sv
// millisecond enable divider
`timescale 1ns/1ps
`default_nettype none
`include "scmc_defs.svh"
module scmc_ms_tick #(
  parameter int MS_CYCLES = `SCMC_MS_CYC
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  output var  logic ms_tick
);
  import scmc_pkg::*;
  logic [16:0] count;
  logic [16:0] next_count;
  logic        next_tick;
  always_comb begin
    next_tick = 1'b0;
    next_count = count + 17'h0_0001;
    if (count == 17'(MS_CYCLES - 1)) begin
      next_count = 17'h0_0000;
      next_tick = 1'b1;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 17'h0_0000;
      ms_tick <= 1'b0;
    end else begin
      count <= next_count;
      ms_tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/scmc_top.sv
// serial command mode entry, exit and i/o settings
`timescale 1ns/1ps
`default_nettype none
`include "scmc_defs.svh"
module scmc_top #(
  parameter logic [15:0] FW_VERSION = 16'h1234, // arbitrary value
  parameter logic [15:0] HW_VERSION = 16'h5678, // arbitrary value
  parameter int          MS_CYCLES  = `SCMC_MS_CYC // clock cycles per millisecond
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        cmd_valid,
  input  wire scmc_pkg::scmc_op_t cmd_op,
  input  wire logic [7:0]  cmd_arg,
  input  wire logic        cfg_we,
  input  wire logic [12:0] cfg_pullup_mask,
  input  wire logic [7:0]  cfg_hold_time,
  input  wire logic [11:0] cfg_timeout,
  input  wire logic [11:0] cfg_guard,
  input  wire logic [7:0]  cfg_seq_char,
  input  wire logic        tx_done,
  input  wire logic [9:0]  volt_raw,
  output var  logic        cmd_mode,
  output var  logic [12:0] pullup_enable,
  output var  logic        strength_active,
  output var  logic        button_pulse,
  output var  logic        rsp_valid,
  output var  logic [15:0] rsp_data
);
  import scmc_pkg::*;

  // ----------------------------------------
  // millisecond enable
  // ----------------------------------------
  logic ms_tick;
  scmc_ms_tick #(.MS_CYCLES(MS_CYCLES)) u_tick (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ms_tick  (ms_tick)
  );

  function automatic logic [15:0] scale_mv(input logic [9:0] raw);
    logic [31:0] prod;
    prod = 32'(raw) * `SCMC_VOLT_MUL / `SCMC_VOLT_DIV;
    return prod[15:0];
  endfunction

  function automatic logic [11:0] clamp12(input logic [11:0] v, input logic [11:0] lo, input logic [11:0] hi);
    logic [11:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // ----------------------------------------
  // configuration
  // ----------------------------------------
  logic [12:0] pull_mask;
  logic [7:0]  hold_set;
  logic [11:0] tmo_set;
  logic [11:0] guard_set;
  logic [7:0]  seq_char;
  logic [12:0] next_pull_mask;
  logic [7:0]  next_hold_set;
  logic [11:0] next_tmo_set;
  logic [11:0] next_guard_set;
  logic [7:0]  next_seq_char;

  always_comb begin
    next_pull_mask = pull_mask;
    next_hold_set = hold_set;
    next_tmo_set = tmo_set;
    next_guard_set = guard_set;
    next_seq_char = seq_char;
    if (cfg_we) begin
      next_pull_mask = cfg_pullup_mask;
      next_hold_set = cfg_hold_time;
      next_tmo_set = clamp12(cfg_timeout, `SCMC_TMO_MIN, `SCMC_TMO_MAX);
      next_guard_set = clamp12(cfg_guard, `SCMC_GUARD_MIN, `SCMC_GUARD_MAX);
      next_seq_char = cfg_seq_char;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pull_mask <= `SCMC_PULLUP_RST;
      hold_set <= `SCMC_HOLD_RST;
      tmo_set <= `SCMC_TMO_RST;
      guard_set <= `SCMC_GUARD_RST;
      seq_char <= `SCMC_SEQ_CHAR_RST;
      pullup_enable <= `SCMC_PULLUP_RST;
    end else begin
      pull_mask <= next_pull_mask;
      hold_set <= next_hold_set;
      tmo_set <= next_tmo_set;
      guard_set <= next_guard_set;
      seq_char <= next_seq_char;
      // bit n drives output bit n: 0 line four ... 12 line eleven
      pullup_enable <= next_pull_mask;
    end
  end

  // ----------------------------------------
  // command mode entry and exit
  // ----------------------------------------
  scmc_mode_t  mode;
  scmc_mode_t  next_mode;
  logic [11:0] silence_ms;
  logic [11:0] next_silence_ms;
  logic [1:0]  seq_cnt;
  logic [1:0]  next_seq_cnt;
  logic [6:0]  tenth_ms;
  logic [6:0]  next_tenth_ms;
  logic [11:0] idle_tenths;
  logic [11:0] next_idle_tenths;
  logic        tenth_tick;

  assign tenth_tick = ms_tick && (tenth_ms == `SCMC_TENTH_MS - 7'h01);
  always_comb begin
    next_mode = mode;
    next_seq_cnt = seq_cnt;
    next_tenth_ms = tenth_ms;
    next_idle_tenths = idle_tenths;
    next_silence_ms = silence_ms;
    if (ms_tick && silence_ms != 12'hFFF) begin
      next_silence_ms = silence_ms + 12'h001;
    end
    if (rx_valid) begin
      next_silence_ms = 12'h000;
    end
    if (ms_tick) begin
      next_tenth_ms = tenth_ms + 7'h01;
      if (tenth_tick) begin
        next_tenth_ms = 7'h00;
      end
    end
    case (mode)
      SCMC_IDLE: begin
        next_seq_cnt = 2'h0;
        // strictly above: the free-running ms phase may cut the first ms short
        if (rx_valid && rx_byte == seq_char && silence_ms > guard_set) begin
          next_mode = SCMC_PRE;
          next_seq_cnt = 2'h1;
        end
      end
      SCMC_PRE: begin
        if (rx_valid) begin
          if (rx_byte == seq_char) begin
            next_seq_cnt = seq_cnt + 2'h1;
            if (seq_cnt + 2'h1 == `SCMC_SEQ_COUNT) begin
              next_mode = SCMC_POST;
            end
          end else begin
            next_mode = SCMC_IDLE;
          end
        end
      end
      SCMC_POST: begin
        if (rx_valid) begin
          next_mode = SCMC_IDLE;
        end else if (silence_ms > guard_set) begin
          next_mode = SCMC_CMD;
          next_idle_tenths = 12'h000;
          next_tenth_ms = 7'h00;
        end
      end
      SCMC_CMD: begin
        if (tenth_tick) begin
          next_idle_tenths = idle_tenths + 12'h001;
        end
        if (idle_tenths >= tmo_set) begin
          next_mode = SCMC_IDLE;
        end
        if (cmd_valid) begin
          next_idle_tenths = 12'h000;
          next_tenth_ms = 7'h00;
          if (cmd_op == SCMC_OP_EXIT) begin
            next_mode = SCMC_IDLE;
          end
        end
      end
      default: next_mode = SCMC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= SCMC_IDLE;
      seq_cnt <= 2'h0;
      silence_ms <= 12'h000;
      tenth_ms <= 7'h00;
      idle_tenths <= 12'h000;
      cmd_mode <= 1'b0;
    end else begin
      mode <= next_mode;
      seq_cnt <= next_seq_cnt;
      silence_ms <= next_silence_ms;
      tenth_ms <= next_tenth_ms;
      idle_tenths <= next_idle_tenths;
      cmd_mode <= (next_mode == SCMC_CMD);
    end
  end

  // ----------------------------------------
  // commands and responses
  // ----------------------------------------
  logic        cmd_take;
  logic [7:0]  press_left;
  logic [7:0]  next_press_left;
  logic        next_button;
  logic        next_rsp_valid;
  logic [15:0] next_rsp_data;

  assign cmd_take = cmd_valid && mode == SCMC_CMD;
  always_comb begin
    next_press_left = press_left;
    next_button = 1'b0;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    // one press pulse every other cycle
    if (press_left != 8'h00 && !button_pulse) begin
      next_button = 1'b1;
      next_press_left = press_left - 8'h01;
    end
    if (cmd_take) begin
      case (cmd_op)
        SCMC_OP_BUTTON: next_press_left = cmd_arg;
        SCMC_OP_FW_VER: begin
          next_rsp_valid = 1'b1;
          next_rsp_data = FW_VERSION;
        end
        SCMC_OP_HW_VER: begin
          next_rsp_valid = 1'b1;
          next_rsp_data = HW_VERSION;
        end
        SCMC_OP_VOLT: begin
          next_rsp_valid = 1'b1;
          next_rsp_data = scale_mv(volt_raw);
        end
        default: next_rsp_valid = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      press_left <= 8'h00;
      button_pulse <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
    end else begin
      press_left <= next_press_left;
      button_pulse <= next_button;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
    end
  end

  // ----------------------------------------
  // signal strength hold
  // ----------------------------------------
  logic [7:0] hold_left;
  logic [7:0] next_hold_left;
  logic [6:0] hold_ms;
  logic [6:0] next_hold_ms;
  logic       next_strength;

  always_comb begin
    next_hold_left = hold_left;
    // own 100 ms phase, restarted by each transmission; the free-running ms phase may still cut the first ms short
    next_hold_ms = ms_tick ? ((hold_ms == `SCMC_TENTH_MS - 7'h01) ? 7'h00 : hold_ms + 7'h01) : hold_ms;
    if (tx_done) begin
      next_hold_left = hold_set;
      next_hold_ms = 7'h00;
    end else if (ms_tick && hold_ms == `SCMC_TENTH_MS - 7'h01 && hold_left != 8'h00) begin
      next_hold_left = hold_left - 8'h01;
    end
    next_strength = (hold_set == `SCMC_HOLD_ALWAYS) || (next_hold_left != 8'h00);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_left <= 8'h00;
      hold_ms <= 7'h00;
      strength_active <= 1'b0;
    end else begin
      hold_left <= next_hold_left;
      hold_ms <= next_hold_ms;
      strength_active <= next_strength;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_post_quiet;
    mode == SCMC_POST && !rx_valid && silence_ms > guard_set;
  endsequence

  chk_exit_now: assert property (cmd_take && cmd_op == SCMC_OP_EXIT |=> !cmd_mode)
    else $error("exit command did not leave command mode");
  chk_enter_guard: assert property (s_post_quiet |=> cmd_mode)
    else $error("command mode not entered after guard silence");
  chk_pre_guard: assert property (mode == SCMC_IDLE && rx_valid && silence_ms <= guard_set |=> mode == SCMC_IDLE)
    else $error("entry started without guard silence");
  chk_timeout_exit: assert property (mode == SCMC_CMD && idle_tenths >= tmo_set && !cmd_valid |=> !cmd_mode)
    else $error("inactivity timeout did not exit");
  chk_cmd_restart: assert property (mode == SCMC_CMD && cmd_valid |=> idle_tenths == 12'h000)
    else $error("valid command did not restart timeout");
  chk_fw_version: assert property (cmd_take && cmd_op == SCMC_OP_FW_VER |=> rsp_valid && rsp_data == FW_VERSION)
    else $error("firmware version answer wrong");
  chk_hw_version: assert property (cmd_take && cmd_op == SCMC_OP_HW_VER |=> rsp_valid && rsp_data == HW_VERSION)
    else $error("hardware version answer wrong");
  chk_volt_scale: assert property (cmd_take && cmd_op == SCMC_OP_VOLT |=>
    ({16'h0000, rsp_data} + 32'h0000_0001) * `SCMC_VOLT_DIV > {22'h00_0000, $past(volt_raw)} * `SCMC_VOLT_MUL
    && {16'h0000, rsp_data} * `SCMC_VOLT_DIV <= {22'h00_0000, $past(volt_raw)} * `SCMC_VOLT_MUL)
    else $error("supply voltage scaling wrong");
  chk_hold_always: assert property (hold_set == `SCMC_HOLD_ALWAYS |=> strength_active)
    else $error("strength output not held permanently");
  chk_hold_start: assert property (tx_done && hold_set != 8'h00 && !cfg_we |=> strength_active)
    else $error("strength output not started after transmission");
  chk_pullup_map: assert property (cfg_we |=> pullup_enable == $past(cfg_pullup_mask))
    else $error("pull-up mask not applied");
  chk_button_count: assert property (cmd_take && cmd_op == SCMC_OP_BUTTON && cmd_arg == 8'h02 |=> ##1 button_pulse ##1 !button_pulse ##1 button_pulse ##1 !button_pulse)
    else $error("button press count wrong");
endmodule
`default_nettype wire

// ===== dv/scmc_host_model.sv
// host controller model driving received bytes and decoded commands
`timescale 1ns/1ps
`default_nettype none
module scmc_host_model (
  input  wire logic                core_clk,
  output var  logic                rx_valid,
  output var  logic [7:0]          rx_byte,
  output var  logic                cmd_valid,
  output var  scmc_pkg::scmc_op_t  cmd_op,
  output var  logic [7:0]          cmd_arg
);
  import scmc_pkg::*;
  initial begin
    rx_valid  = 1'b0;
    rx_byte   = 8'h00;
    cmd_valid = 1'b0;
    cmd_op    = SCMC_OP_NONE;
    cmd_arg   = 8'h00;
  end
  // ----------------------------------------
  // byte and command strobes, one cycle each
  // ----------------------------------------
  task automatic send_byte(input logic [7:0] b);
    rx_valid = 1'b1;
    rx_byte  = b;
    @(posedge core_clk);
    #1;
    rx_valid = 1'b0;
    // stale data line shows the inverse
    rx_byte  = ~b;
    // one quiet cycle keeps strobes of back-to-back calls apart
    @(posedge core_clk);
    #1;
  endtask
  task automatic send_seq(input logic [7:0] c);
    repeat (3) send_byte(c);
  endtask
  task automatic send_cmd(input scmc_op_t op, input logic [7:0] arg);
    cmd_valid = 1'b1;
    cmd_op    = op;
    cmd_arg   = arg;
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    cmd_op    = SCMC_OP_NONE;
    cmd_arg   = ~arg;
  endtask
endmodule
`default_nettype wire

// ===== dv/serial_command_mode_control_tb_top.sv
// self-checking bench for the serial command mode controller
`timescale 1ns/1ps
`default_nettype none
module serial_command_mode_control_tb_top;
  import scmc_pkg::*;
  // shortened millisecond keeps guard and timeout runs short
  localparam int MS = 50;
  logic core_clk = 1'b0, rst_n = 1'b0, cfg_we = 1'b0, tx_done = 1'b0;
  logic [12:0] cfg_pullup_mask = 13'h1FFF;
  logic [7:0]  cfg_hold_time = 8'h28, cfg_seq_char = 8'h41, cmd_arg;
  logic [11:0] cfg_timeout = 12'h28F, cfg_guard = 12'h001;
  logic [9:0]  volt_raw = 10'h000;
  logic        rx_valid, cmd_valid, cmd_mode, strength_active, button_pulse, rsp_valid;
  logic [7:0]  rx_byte;
  logic [12:0] pullup_enable;
  logic [15:0] rsp_data;
  scmc_op_t    cmd_op;
  int          n_fail = 0, cmp_count = 0, k;
  always #4 core_clk = ~core_clk;
  scmc_host_model scmc_host_model_i (.core_clk(core_clk), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_arg(cmd_arg));
  scmc_top #(.FW_VERSION(16'hA1C3), .HW_VERSION(16'h0B7E), .MS_CYCLES(MS)) scmc_top_i (
    .core_clk(core_clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_arg(cmd_arg), .cfg_we(cfg_we),
    .cfg_pullup_mask(cfg_pullup_mask), .cfg_hold_time(cfg_hold_time), .cfg_timeout(cfg_timeout),
    .cfg_guard(cfg_guard), .cfg_seq_char(cfg_seq_char), .tx_done(tx_done), .volt_raw(volt_raw),
    .cmd_mode(cmd_mode), .pullup_enable(pullup_enable), .strength_active(strength_active),
    .button_pulse(button_pulse), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask
  task automatic cfg(input logic [12:0] mask, input logic [7:0] hold);
    cfg_pullup_mask = mask;
    cfg_hold_time   = hold;
    cfg_we = 1'b1;
    tick(1);
    cfg_we = 1'b0;
    tick(1);
  endtask
  task automatic enter_cmd;
    scmc_host_model_i.send_seq(8'h41);
    tick(MS - 2);
    chk_bit(cmd_mode, 1'b0, "entry before trailing guard");
    k = 0;
    while (cmd_mode !== 1'b1 && k < 3 * MS) begin
      tick(1);
      k++;
    end
    chk_bit(cmd_mode, 1'b1, "entry after guard");
  endtask
  task automatic rsp(input scmc_op_t op, input logic [15:0] exp);
    scmc_host_model_i.send_cmd(op, 8'h00);
    chk_bit(rsp_valid, 1'b1, "answer strobe");
    chk_word(rsp_data, exp, "answer data");
    tick(1);
    chk_bit(rsp_valid, 1'b0, "answer strobe width");
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk_word({3'h0, pullup_enable}, 16'h1FFF, "pull-up reset");
    chk_bit(cmd_mode, 1'b0, "mode reset");
    chk_bit(strength_active, 1'b0, "strength reset");
    chk_bit(button_pulse, 1'b0, "button reset");
    chk_word(rsp_data, 16'h0000, "answer reset");
    scmc_host_model_i.send_cmd(SCMC_OP_FW_VER, 8'h00);
    chk_bit(rsp_valid, 1'b0, "query outside command mode");
    $display("test reset done");
  endtask
  task automatic t_pullup;
    logic [12:0] m [3] = '{13'h0A5A, 13'h0001, 13'h1000};
    foreach (m[i]) begin
      cfg(m[i], 8'h00);
      chk_word({3'h0, pullup_enable}, {3'h0, m[i]}, "pull-up mask");
    end
    $display("test pullup done");
  endtask
  task automatic t_strength;
    tx_done = 1'b1;
    tick(1);
    tx_done = 1'b0;
    tick(2);
    chk_bit(strength_active, 1'b0, "zero hold stays off");
    cfg(13'h1FFF, 8'hFF);
    tick(2000);
    chk_bit(strength_active, 1'b1, "all-ones hold stays on");
    cfg(13'h1FFF, 8'h01);
    tick(1);
    chk_bit(strength_active, 1'b0, "hold leaves all-ones");
    tx_done = 1'b1;
    tick(1);
    tx_done = 1'b0;
    chk_bit(strength_active, 1'b1, "hold starts");
    tick(95 * MS);
    chk_bit(strength_active, 1'b1, "hold still on");
    tick(10 * MS);
    chk_bit(strength_active, 1'b0, "hold ended");
    $display("test strength done");
  endtask
  task automatic t_entry;
    tick(2 * MS);
    scmc_host_model_i.send_seq(8'h2B);
    tick(2 * MS + MS / 2);
    chk_bit(cmd_mode, 1'b0, "old character enters");
    enter_cmd();
    $display("test entry done");
  endtask
  task automatic t_cmds;
    logic [9:0] raw [2] = '{10'h3FF, 10'h2B5};
    logic [31:0] e;
    logic [7:0] presses [2] = '{8'h03, 8'h02};
    rsp(SCMC_OP_FW_VER, 16'hA1C3);
    rsp(SCMC_OP_HW_VER, 16'h0B7E);
    foreach (raw[i]) begin
      volt_raw = raw[i];
      e = {22'h0, raw[i]} * 32'h0000_04B0 / 32'h0000_03FF;
      rsp(SCMC_OP_VOLT, e[15:0]);
    end
    foreach (presses[i]) begin
      scmc_host_model_i.send_cmd(SCMC_OP_BUTTON, presses[i]);
      k = 0;
      repeat (12) begin
        if (button_pulse === 1'b1) k++;
        tick(1);
      end
      chk_word(16'(k), {8'h00, presses[i]}, "press count");
    end
    $display("test commands done");
  endtask
  task automatic t_exit;
    scmc_host_model_i.send_cmd(SCMC_OP_EXIT, 8'h00);
    chk_bit(cmd_mode, 1'b0, "exit command");
    tick(1);
    scmc_host_model_i.send_cmd(SCMC_OP_HW_VER, 8'h00);
    chk_bit(rsp_valid, 1'b0, "query after exit");
    $display("test exit done");
  endtask
  task automatic t_timeout;
    cfg_timeout = 12'h002;
    cfg(13'h1FFF, 8'h00);
    scmc_host_model_i.send_byte(8'h00);
    scmc_host_model_i.send_seq(8'h41);
    tick(3 * MS);
    chk_bit(cmd_mode, 1'b0, "entry without leading guard");
    enter_cmd();
    tick(150 * MS);
    chk_bit(cmd_mode, 1'b1, "timeout too early");
    scmc_host_model_i.send_cmd(SCMC_OP_OTHER, 8'h00);
    tick(150 * MS);
    chk_bit(cmd_mode, 1'b1, "command restarts timeout");
    tick(60 * MS);
    chk_bit(cmd_mode, 1'b0, "inactivity timeout");
    $display("test timeout done");
  endtask
  initial begin
    tick(8);
    rst_n = 1'b1;
    tick(1);
    t_reset();
    t_pullup();
    t_strength();
    t_entry();
    t_cmds();
    t_exit();
    t_timeout();
    test_done();
  end
  // about three times the expected run of some 26000 cycles
  initial begin
    #600_000;
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
